// >>> rtl/pocss_top.v
// Contract
// - Power-on clock chosen from mode and select fields
// - Mode 11 maps internal and secondary codes
// - Codes 011/010 select primary with/without PLL
// - Erased configuration gives RC with postscaler
// - Switching allowed only when upper bit zero
// - Monitor active only when both bits zero
// - Monitor detects primary or secondary clock failure
// - Fast RC 8 MHz, divider lowers it
// - RC divided-by-16 mode gives 500 kHz
// - Exactly one of four sources selected
// - Only primary and fast RC feed PLL
// - Instruction clock is processor clock halved
// - Instruction clock may drive output pin
// - Config bit sets output pin function
// - Current and new selection reset from config
// - Switch enable starts switch, clears when done
`include "pocss_defines.vh"
`default_nettype none

module pocss_top #(
  parameter [15:0] FAIL_CYC = `POCSS_FAIL_CYC
) (
  input wire clk,
  input wire rstn,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire [1:0] primary_osc_mode_field,
  input wire [2:0] initial_osc_select_field,
  input wire [1:0] switch_monitor_cfg_field,
  input wire osc_out_pin_function_bit,
  input wire primary_osc_input_pin,
  input wire secondary_osc_pin,
  output reg primary_osc_output_pin,
  output reg primary_osc_output_pin_oe,
  output reg [3:0] clk_source_onehot_q,
  output reg [2:0] sys_div_log2_q,
  output reg pll_enable_q,
  output reg unsupported_cfg_q,
  output reg instr_clk_q,
  output wire irq
);

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------
  function mode_valid;
    input [1:0] pm;
    input [2:0] sel;
    begin
      case (sel)
        `POCSS_SEL_PRIPLL: mode_valid = (pm == `POCSS_PM_XTAL) || (pm == `POCSS_PM_EXTCLK);
        `POCSS_SEL_PRI: mode_valid = (pm != `POCSS_PM_OFF);
        default: mode_valid = (pm == `POCSS_PM_OFF);
      endcase
    end
  endfunction

  function [3:0] src_of;
    input [2:0] sel;
    begin
      case (sel)
        `POCSS_SEL_PRI, `POCSS_SEL_PRIPLL: src_of = 4'h1 << `POCSS_SRC_PRI;
        `POCSS_SEL_SEC: src_of = 4'h1 << `POCSS_SRC_SEC;
        `POCSS_SEL_LOWPWR: src_of = 4'h1 << `POCSS_SRC_LOWPWR;
        default: src_of = 4'h1 << `POCSS_SRC_RC;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  reg rst_meta_q;
  reg rst_sync_q;
  wire rst_n = rst_sync_q;

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and activity detect
  // ----------------------------------------------------------------
  reg [2:0] pri_sync_q;
  reg [2:0] sec_sync_q;
  wire pri_edge = pri_sync_q[1] ^ pri_sync_q[2];
  wire sec_edge = sec_sync_q[1] ^ sec_sync_q[2];

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pri_sync_q <= 3'h0;
      sec_sync_q <= 3'h0;
    end
    else
    begin
      pri_sync_q <= {pri_sync_q[1:0], primary_osc_input_pin};
      sec_sync_q <= {sec_sync_q[1:0], secondary_osc_pin};
    end
  end

  // ----------------------------------------------------------------
  // Configuration latch and oscillator selection
  // ----------------------------------------------------------------
  localparam [2:0] ST_LOAD = 3'b001;
  localparam [2:0] ST_IDLE = 3'b010;
  localparam [2:0] ST_SWITCH = 3'b100;

  reg [2:0] state_q;
  reg [1:0] pm_q;
  reg [2:0] init_sel_q;
  reg [1:0] sw_mon_cfg_q;
  reg pin_func_q;
  reg [2:0] cur_sel_q;
  reg [2:0] new_sel_q;
  reg swen_q;
  reg [2:0] rcdiv_q;
  reg [7:0] sw_cnt_q;
  reg [15:0] mon_cnt_q;
  reg [2:0] stat_q;
  reg [2:0] mask_q;
  reg ack_q;

  wire bus_req = avs_read | avs_write;
  wire bus_wr = avs_write & ack_q;
  wire switch_ok = ~sw_mon_cfg_q[1];
  wire monitor_on = (sw_mon_cfg_q == 2'b00);
  wire cur_is_pri = (cur_sel_q == `POCSS_SEL_PRI) || (cur_sel_q == `POCSS_SEL_PRIPLL);
  wire mon_edge = cur_is_pri ? pri_edge : sec_edge;
  wire mon_watch = monitor_on && (state_q == ST_IDLE) &&
                   (cur_is_pri || (cur_sel_q == `POCSS_SEL_SEC));
  wire clk_fail = mon_watch && (mon_cnt_q == FAIL_CYC - 16'h1);

  wire wr_ctrl = bus_wr && (avs_address == `POCSS_ADDR_CTRL);
  wire wr_div = bus_wr && (avs_address == `POCSS_ADDR_DIV);
  wire wr_stat = bus_wr && (avs_address == `POCSS_ADDR_IRQ_STAT);
  wire wr_mask = bus_wr && (avs_address == `POCSS_ADDR_IRQ_MASK);
  wire swen_req = wr_ctrl && avs_byteenable[0] && avs_writedata[`POCSS_CTRL_SWEN_BIT];
  // A switch is judged on the select written in the same access
  wire new_sel_wr = wr_ctrl && avs_byteenable[1] && (state_q != ST_SWITCH);
  wire [2:0] new_sel_nxt = new_sel_wr ? avs_writedata[`POCSS_CTRL_NEW_LSB +: 3] : new_sel_q;

  reg ev_done;
  reg ev_refused;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_LOAD;
      pm_q <= `POCSS_PM_OFF;
      init_sel_q <= `POCSS_RST_SEL;
      sw_mon_cfg_q <= 2'b11;
      pin_func_q <= 1'b0;
      cur_sel_q <= `POCSS_RST_SEL;
      new_sel_q <= `POCSS_RST_SEL;
      swen_q <= 1'b0;
      rcdiv_q <= `POCSS_RST_RCDIV;
      sw_cnt_q <= 8'h0;
      mon_cnt_q <= 16'h0;
      ev_done <= 1'b0;
      ev_refused <= 1'b0;
    end
    else
    begin
      ev_done <= 1'b0;
      ev_refused <= 1'b0;
      if (wr_div && avs_byteenable[1])
        rcdiv_q <= avs_writedata[10:8];
      if (new_sel_wr)
        new_sel_q <= new_sel_nxt;
      if (mon_edge || !mon_watch)
        mon_cnt_q <= 16'h0;
      else if (!clk_fail)
        mon_cnt_q <= mon_cnt_q + 16'h1;
      case (state_q)
        ST_LOAD:
        begin
          pm_q <= primary_osc_mode_field;
          init_sel_q <= initial_osc_select_field;
          sw_mon_cfg_q <= switch_monitor_cfg_field;
          pin_func_q <= osc_out_pin_function_bit;
          cur_sel_q <= initial_osc_select_field;
          new_sel_q <= initial_osc_select_field;
          state_q <= ST_IDLE;
        end
        ST_IDLE:
        begin
          if (clk_fail)
          begin
            cur_sel_q <= `POCSS_SEL_RC;
            new_sel_q <= `POCSS_SEL_RC;
          end
          else if (swen_req)
          begin
            if (switch_ok && mode_valid(pm_q, new_sel_nxt))
            begin
              swen_q <= 1'b1;
              sw_cnt_q <= 8'h0;
              state_q <= ST_SWITCH;
            end
            else
              ev_refused <= 1'b1;
          end
        end
        ST_SWITCH:
        begin
          if (sw_cnt_q == `POCSS_SWITCH_CYC - 1)
          begin
            cur_sel_q <= new_sel_q;
            swen_q <= 1'b0;
            ev_done <= 1'b1;
            state_q <= ST_IDLE;
          end
          else
            sw_cnt_q <= sw_cnt_q + 8'h1;
        end
        default:
          state_q <= ST_LOAD;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Clock mode outputs
  // ----------------------------------------------------------------
  wire cur_crystal = cur_is_pri && (pm_q != `POCSS_PM_EXTCLK);

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_source_onehot_q <= 4'h1 << `POCSS_SRC_RC;
      sys_div_log2_q <= 3'h0;
      pll_enable_q <= 1'b0;
      unsupported_cfg_q <= 1'b0;
      instr_clk_q <= 1'b0;
      primary_osc_output_pin <= 1'b0;
      primary_osc_output_pin_oe <= 1'b0;
    end
    else
    begin
      clk_source_onehot_q <= src_of(cur_sel_q);
      case (cur_sel_q)
        `POCSS_SEL_RC_POST, `POCSS_SEL_RC_PLL: sys_div_log2_q <= rcdiv_q;
        `POCSS_SEL_RC16: sys_div_log2_q <= `POCSS_RC16_LOG2;
        default: sys_div_log2_q <= 3'h0;
      endcase
      pll_enable_q <= (cur_sel_q == `POCSS_SEL_RC_PLL) ||
                      (cur_sel_q == `POCSS_SEL_PRIPLL);
      unsupported_cfg_q <= (state_q != ST_LOAD) && !mode_valid(pm_q, init_sel_q);
      instr_clk_q <= ~instr_clk_q;
      primary_osc_output_pin <= instr_clk_q;
      primary_osc_output_pin_oe <= (state_q != ST_LOAD) && pin_func_q &&
                                   !cur_crystal;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  wire [2:0] ev_vec = {ev_refused, ev_done, clk_fail};

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stat_q <= 3'h0;
      mask_q <= 3'h0;
    end
    else
    begin
      if (wr_stat && avs_byteenable[0])
        stat_q <= (stat_q & ~avs_writedata[2:0]) | ev_vec;
      else
        stat_q <= stat_q | ev_vec;
      if (wr_mask && avs_byteenable[0])
        mask_q <= avs_writedata[2:0];
    end
  end

  assign irq = |(stat_q & mask_q);

  // ----------------------------------------------------------------
  // Avalon-MM slave: one wait cycle per access
  // ----------------------------------------------------------------
  assign avs_waitrequest = bus_req & ~ack_q;

  reg [31:0] rd_mux;

  always @*
  begin
    rd_mux = 32'h0;
    case (avs_address)
      `POCSS_ADDR_CTRL:
      begin
        rd_mux[`POCSS_CTRL_CUR_LSB +: 3] = cur_sel_q;
        rd_mux[`POCSS_CTRL_NEW_LSB +: 3] = new_sel_q;
        rd_mux[`POCSS_CTRL_SWEN_BIT] = swen_q;
      end
      `POCSS_ADDR_DIV: rd_mux[10:8] = rcdiv_q;
      `POCSS_ADDR_CFG:
        rd_mux[11:0] = {unsupported_cfg_q, init_sel_q, sw_mon_cfg_q, pin_func_q,
                        monitor_on, switch_ok, 1'b0, pm_q};
      `POCSS_ADDR_IRQ_STAT: rd_mux[2:0] = stat_q;
      `POCSS_ADDR_IRQ_MASK: rd_mux[2:0] = mask_q;
      default: rd_mux = 32'h0;
    endcase
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_q <= 1'b0;
      avs_readdata <= 32'h0;
    end
    else
    begin
      ack_q <= bus_req & ~ack_q;
      if (avs_read && !ack_q)
        avs_readdata <= rd_mux;
    end
  end

endmodule

`default_nettype wire

// >>> rtl/pocss_defines.vh
`ifndef POCSS_DEFINES_VH
`define POCSS_DEFINES_VH

// Register word addresses
`define POCSS_ADDR_CTRL 4'h0
`define POCSS_ADDR_DIV 4'h1
`define POCSS_ADDR_CFG 4'h2
`define POCSS_ADDR_IRQ_STAT 4'h3
`define POCSS_ADDR_IRQ_MASK 4'h4

// Control register fields
`define POCSS_CTRL_SWEN_BIT 0
`define POCSS_CTRL_NEW_LSB 8
`define POCSS_CTRL_CUR_LSB 12

// Status / mask bits
`define POCSS_IRQ_FAIL 0
`define POCSS_IRQ_DONE 1
`define POCSS_IRQ_REFUSED 2

// Oscillator selection codes
`define POCSS_SEL_RC 3'h0
`define POCSS_SEL_RC_PLL 3'h1
`define POCSS_SEL_PRI 3'h2
`define POCSS_SEL_PRIPLL 3'h3
`define POCSS_SEL_SEC 3'h4
`define POCSS_SEL_LOWPWR 3'h5
`define POCSS_SEL_RC16 3'h6
`define POCSS_SEL_RC_POST 3'h7

// Primary mode field codes
`define POCSS_PM_EXTCLK 2'h0
`define POCSS_PM_XTAL 2'h1
`define POCSS_PM_FAST_XTAL 2'h2
`define POCSS_PM_OFF 2'h3

// Source one-hot positions
`define POCSS_SRC_PRI 0
`define POCSS_SRC_SEC 1
`define POCSS_SRC_RC 2
`define POCSS_SRC_LOWPWR 3

// Reset values and RC16 divider log2
`define POCSS_RST_SEL 3'h7
`define POCSS_RST_RCDIV 3'h1
`define POCSS_RC16_LOG2 3'h4

// Timing: clock period 4 ns, switch settle 100 ns, monitor timeout 20000 ns
`define POCSS_CLK_NS 4
`define POCSS_SWITCH_NS 100
`define POCSS_SWITCH_CYC (`POCSS_SWITCH_NS / `POCSS_CLK_NS)
`define POCSS_FAIL_NS 20000
`define POCSS_FAIL_CYC (`POCSS_FAIL_NS / `POCSS_CLK_NS)

`endif

// >>> verif/pocss_assertions.sv
`default_nettype none
module pocss_checker #(
  parameter int FAIL_CYC = 64
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [1:0] primary_osc_mode_field,
  input wire logic [1:0] switch_monitor_cfg_field,
  input wire logic osc_out_pin_function_bit,
  input wire logic primary_osc_output_pin,
  input wire logic primary_osc_output_pin_oe,
  input wire logic [3:0] clk_source_onehot_q,
  input wire logic [2:0] sys_div_log2_q,
  input wire logic pll_enable_q,
  input wire logic unsupported_cfg_q,
  input wire logic instr_clk_q,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] up_q;
  // ----------------------------------------
  // Cycles since reset release, saturating
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      up_q <= 3'h0;
    else if (up_q != 3'h7)
      up_q <= up_q + 3'h1;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  src_onehot_a: assert property ($onehot(clk_source_onehot_q))
    else $error("clock source not one-hot");
  instr_half_a: assert property (up_q == 3'h7 |=> instr_clk_q != $past(instr_clk_q))
    else $error("instruction clock not half rate");
  pin_copy_a: assert property (primary_osc_output_pin_oe |=>
    primary_osc_output_pin != $past(primary_osc_output_pin))
    else $error("output pin not toggling while driven");
  oe_mode_a: assert property (primary_osc_output_pin_oe |-> osc_out_pin_function_bit &&
    (primary_osc_mode_field == 2'h0 || primary_osc_mode_field == 2'h3))
    else $error("output pin driven in wrong mode");
  pll_src_a: assert property (pll_enable_q |-> clk_source_onehot_q[0] || clk_source_onehot_q[2])
    else $error("pll fed by wrong source");
  div_src_a: assert property (!clk_source_onehot_q[2] |-> sys_div_log2_q == 3'h0)
    else $error("divider applied to non rc source");
  lock_src_a: assert property ((up_q == 3'h7 && switch_monitor_cfg_field[1])
    |-> $stable(clk_source_onehot_q))
    else $error("source changed while switching locked");
  unsup_hold_a: assert property (unsupported_cfg_q |=> unsupported_cfg_q)
    else $error("unsupported flag dropped");
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest longer than one cycle");
  cover property (irq);
  cover property (pll_enable_q);
  cover property (unsupported_cfg_q);
  cover property ($fell(clk_source_onehot_q[0]));
endmodule
bind pocss_top pocss_checker #(.FAIL_CYC(FAIL_CYC)) chk_u (.clk(clk), .rstn(rstn),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .primary_osc_mode_field(primary_osc_mode_field),
  .switch_monitor_cfg_field(switch_monitor_cfg_field),
  .osc_out_pin_function_bit(osc_out_pin_function_bit),
  .primary_osc_output_pin(primary_osc_output_pin),
  .primary_osc_output_pin_oe(primary_osc_output_pin_oe),
  .clk_source_onehot_q(clk_source_onehot_q), .sys_div_log2_q(sys_div_log2_q),
  .pll_enable_q(pll_enable_q), .unsupported_cfg_q(unsupported_cfg_q),
  .instr_clk_q(instr_clk_q), .irq(irq));
`default_nettype wire

// >>> verif/pocss_osc_model.sv
`default_nettype none
module pocss_osc_model (
  input wire logic pri_run,
  output logic pri_pin,
  output logic sec_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pri_pin = 1'b0;
  initial sec_pin = 1'b0;
  // Primary stops on demand to emulate a dead crystal
  always #10 if (pri_run) pri_pin = !pri_pin;
  always #37 sec_pin = !sec_pin;
endmodule
`default_nettype wire

// >>> verif/power_on_clock_source_select_test.sv
`default_nettype none
module power_on_clock_source_select_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] CFGS [12] = '{5'h1f, 5'h1e, 5'h1d, 5'h1c, 5'h0b, 5'h03, 5'h12,
    5'h0a, 5'h02, 5'h19, 5'h18, 5'h13};
  logic clk, rstn, avs_read, avs_write, pf, pri_run, pri_pin, sec_pin, wreq, opin, oe;
  logic pll, uns, instr, irq;
  logic [3:0] avs_address, oh;
  logic [31:0] avs_writedata, avs_readdata;
  logic [1:0] pm, fk;
  logic [2:0] sel, div;
  int n_errors = 0;
  int tests_run = 0;
  pocss_top #(.FAIL_CYC(16'd64)) dut_u (.clk(clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(wreq),
    .primary_osc_mode_field(pm), .initial_osc_select_field(sel),
    .switch_monitor_cfg_field(fk), .osc_out_pin_function_bit(pf),
    .primary_osc_input_pin(pri_pin), .secondary_osc_pin(sec_pin),
    .primary_osc_output_pin(opin), .primary_osc_output_pin_oe(oe),
    .clk_source_onehot_q(oh), .sys_div_log2_q(div), .pll_enable_q(pll),
    .unsupported_cfg_q(uns), .instr_clk_q(instr), .irq(irq));
  pocss_osc_model osc_u (.pri_run(pri_run), .pri_pin(pri_pin), .sec_pin(sec_pin));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task final_report;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
    output logic [31:0] q);
    logic ws;
    int i;
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    ws = 1'b1;
    i = 0;
    while (ws && i < 20)
    begin
      @(posedge clk);
      ws = wreq;
      q = avs_readdata;
      i++;
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (ws !== 1'b0)
    begin
      n_errors++;
      final_report();
    end
  endtask
  task cfg(input logic [1:0] m, input logic [2:0] s, input logic [1:0] f, input logic p);
    @(posedge clk);
    rstn <= 1'b0;
    pm <= m;
    sel <= s;
    fk <= f;
    pf <= p;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  task automatic t_table;
    logic [2:0] s;
    logic [1:0] m;
    logic [31:0] q;
    for (int i = 0; i < 12; i++)
    begin
      s = CFGS[i][2:0];
      m = CFGS[i][4:3];
      cfg(m, s, 2'h3, 1'b1);
      chk(oh, 4'h1 << ((s == 3'h2 || s == 3'h3) ? 0 : s == 3'h4 ? 1 : s == 3'h5 ? 3 : 2), "src");
      chk({uns, pll, oe, div}, {i == 11, s == 3'h1 || s == 3'h3, m == 2'h0 || m == 2'h3,
        (s == 3'h7 || s == 3'h1) ? 3'h1 : (s == 3'h6) ? 3'h4 : 3'h0}, "mode outputs");
      bus(1'b0, 4'h0, 32'h0, q);
      chk(q[14:8], {s, 1'b0, s}, "select reset");
      if (s == 3'h7 && m == 2'h3)
      begin
        bus(1'b1, 4'h1, 32'h500, q);
        repeat (2) @(posedge clk);
        chk(div, 3'h5, "postscaler");
      end
    end
  endtask
  task automatic t_switch;
    logic [31:0] q;
    int i;
    cfg(2'h3, 3'h0, 2'h0, 1'b0);
    bus(1'b1, 4'h4, 32'h7, q);
    bus(1'b1, 4'h0, 32'h201, q);
    bus(1'b0, 4'h3, 32'h0, q);
    chk({q[2:0], oh}, {3'h4, 4'h4}, "bad select refused");
    bus(1'b1, 4'h3, 32'h4, q);
    bus(1'b1, 4'h0, 32'h501, q);
    q = 32'h1;
    for (i = 0; i < 40 && q[0] !== 1'b0; i++) bus(1'b0, 4'h0, 32'h0, q);
    chk({q[14:12], q[0], oh, irq}, {3'h5, 1'b0, 4'h8, 1'b1}, "switch done");
    bus(1'b0, 4'h3, 32'h0, q);
    chk(q[2:0], 3'h2, "done status");
    bus(1'b1, 4'h4, 32'h0, q);
    @(posedge clk);
    chk(irq, 1'b0, "masked irq");
    bus(1'b1, 4'h4, 32'h2, q);
    @(posedge clk);
    chk(irq, 1'b1, "unmasked irq");
    bus(1'b1, 4'h3, 32'h2, q);
    @(posedge clk);
    chk(irq, 1'b0, "cleared irq");
    bus(1'b0, 4'hf, 32'h0, q);
    chk(q, 32'h0, "unmapped read");
  endtask
  task automatic t_refuse;
    logic [31:0] q;
    cfg(2'h3, 3'h0, 2'h2, 1'b0);
    bus(1'b1, 4'h0, 32'h501, q);
    bus(1'b0, 4'h3, 32'h0, q);
    chk(q[2], 1'b1, "refused status");
    bus(1'b0, 4'h0, 32'h0, q);
    chk({q[14:12], q[0], oh}, {3'h0, 1'b0, 4'h4}, "source kept");
  endtask
  task automatic mon(input logic [1:0] f, input logic exp);
    logic [31:0] q;
    int i;
    cfg(2'h1, 3'h2, f, 1'b0);
    pri_run <= 1'b0;
    q = 32'h0;
    for (i = 0; i < 60 && q[0] !== 1'b1; i++) bus(1'b0, 4'h3, 32'h0, q);
    chk({q[0], oh}, {exp, exp ? 4'h4 : 4'h1}, "monitor");
    pri_run <= 1'b1;
  endtask
  initial
  begin
    rstn = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    pm = 2'h3;
    sel = 3'h7;
    fk = 2'h3;
    pf = 1'b0;
    pri_run = 1'b1;
    t_table();
    t_switch();
    t_refuse();
    mon(2'h0, 1'b1);
    mon(2'h1, 1'b0);
    final_report();
  end
endmodule
`default_nettype wire
